// File: src/esx_exec.sv
// Execute logic for the add-to-pointer, add-and-return and computed-call opcodes.
// Assumes the decode stage presents one instruction per cycle with a valid strobe,
// and that the pointer file and return stack apply the write strobes given here.
`timescale 1ns/100ps
`default_nettype none

module esx_exec (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  // Configuration
  input  wire logic                        extended_set_enable_bit_i,
  // Instruction from decode
  input  wire logic                        instr_valid_i,
  input  wire logic [15:0]                 instr_i,
  // Core state
  input  wire logic [esx_pkg::PC_W-1:0]    pc_i,
  input  wire logic [7:0]                  working_reg_i,
  input  wire logic [7:0]                  program_counter_high_latch_i,
  input  wire logic [7:0]                  program_counter_upper_latch_i,
  input  wire logic [esx_pkg::PC_W-1:0]    return_stack_top_i,
  input  wire logic [esx_pkg::PTR_W-1:0]   indirect_pointer0_i,
  input  wire logic [esx_pkg::PTR_W-1:0]   indirect_pointer1_i,
  input  wire logic [esx_pkg::PTR_W-1:0]   software_stack_pointer_i,
  // Pointer write-back
  output logic                             ptr_we_o,
  output logic [1:0]                       ptr_sel_o,
  output logic [esx_pkg::PTR_W-1:0]        ptr_wdata_o,
  // Return stack
  output logic                             stack_push_o,
  output logic                             stack_pop_o,
  output logic [esx_pkg::PC_W-1:0]         stack_push_data_o,
  // Program counter load
  output logic                             pc_load_o,
  output logic [esx_pkg::PC_W-1:0]         pc_load_data_o,
  // Pipeline control
  output logic                             flush_o,
  output logic                             busy_o
);

  // ****************************************
  // Synchronise the configuration bit
  // ****************************************
  // Configuration fuse comes from outside the core clock, so two flops first
  logic ext_meta_q, ext_meta_d;
  logic ext_sync_q, ext_sync_d;

  always_comb begin
    ext_meta_d = extended_set_enable_bit_i;
    ext_sync_d = ext_meta_q;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_meta_q <= esx_pkg::EXT_RESET;
      ext_sync_q <= esx_pkg::EXT_RESET;
    end else begin
      ext_meta_q <= ext_meta_d;
      ext_sync_q <= ext_sync_d;
    end
  end

  // ****************************************
  // Decode and execute
  // ****************************************
  // Opcode tests live in one place so decode and checks cannot drift apart
  // Add-to-pointer family: fixed upper byte, select and literal below it
  function automatic logic is_add_ptr(input logic [15:0] word);
    is_add_ptr = (word[15:8] == esx_pkg::ADD_PTR_HI);
  endfunction : is_add_ptr

  // Computed call: the whole word is fixed, no operand to extract
  function automatic logic is_call_wreg(input logic [15:0] word);
    is_call_wreg = (word == esx_pkg::CALL_WREG_OP);
  endfunction : is_call_wreg

  // Select field of the add family; 3 means stack pointer plus return
  function automatic logic [1:0] sel_field(input logic [15:0] word);
    sel_field = word[esx_pkg::SEL_MSB:esx_pkg::SEL_LSB];
  endfunction : sel_field

  // Literal zero-extended to pointer width; the add never sees a sign
  function automatic logic [esx_pkg::PTR_W-1:0] lit_ext(input logic [15:0] word);
    lit_ext = {{(esx_pkg::PTR_W-esx_pkg::LIT_MSB-1){1'b0}}, word[esx_pkg::LIT_MSB:0]};
  endfunction : lit_ext

  // Jump target of the computed call: upper latch, high latch, then W
  function automatic logic [esx_pkg::PC_W-1:0] call_target(input logic [7:0] upper,
                                                           input logic [7:0] high,
                                                           input logic [7:0] low);
    call_target = {upper[esx_pkg::PC_W-17:0], high, low};
  endfunction : call_target

  // Address after a one-word instruction; wraps at the PC width
  function automatic logic [esx_pkg::PC_W-1:0] next_instr_addr(input logic [esx_pkg::PC_W-1:0] pc);
    next_instr_addr = pc + esx_pkg::PC_STEP;
  endfunction : next_instr_addr

  // ****************************************
  // Opcode decode
  // ****************************************
  // Raw opcode flags; valid, enable and state gating happen in the execute step
  logic                        dec_add_ptr;
  logic                        dec_add_ret;
  logic                        dec_call;

  // Decode once per cycle from the word on the input
  always_comb begin
    dec_add_ptr = is_add_ptr(instr_i);
    dec_add_ret = dec_add_ptr && (sel_field(instr_i) == esx_pkg::SEL_STACK);
    dec_call    = is_call_wreg(instr_i);
  end

  // ****************************************
  // Execute state and strobes
  // ****************************************
  // Two states: taking instructions, or the idle slot of a two-cycle op
  esx_pkg::esx_state_e state_q, state_d;
  logic                        ptr_we_d, stack_push_d, stack_pop_d, pc_load_d, flush_d, busy_d;
  logic [1:0]                  ptr_sel_d;
  logic [esx_pkg::PTR_W-1:0]   ptr_wdata_d;
  logic [esx_pkg::PC_W-1:0]    push_data_d, pc_data_d;

  // Pick the pointer named by the select field
  function automatic logic [esx_pkg::PTR_W-1:0] pick_ptr(input logic [1:0] sel,
                                                         input logic [esx_pkg::PTR_W-1:0] p0,
                                                         input logic [esx_pkg::PTR_W-1:0] p1,
                                                         input logic [esx_pkg::PTR_W-1:0] p2);
    case (sel)
      2'h0:    pick_ptr = p0;
      2'h1:    pick_ptr = p1;
      default: pick_ptr = p2;
    endcase
  endfunction : pick_ptr

  // ****************************************
  // Next values for state and strobes
  // ****************************************
  // Defaults first so every output has a value on every path
  always_comb begin
    logic [1:0]                sel;
    logic [esx_pkg::PTR_W-1:0] lit;
    sel          = sel_field(instr_i);
    lit          = lit_ext(instr_i);
    state_d      = esx_pkg::ESX_EXEC;
    ptr_we_d     = 1'b0;
    ptr_sel_d    = sel;
    // Sum wraps at pointer width; no carry or flag leaves this block
    ptr_wdata_d  = pick_ptr(sel, indirect_pointer0_i, indirect_pointer1_i, software_stack_pointer_i)
                   + lit;                                // unsigned literal, no flags produced
    stack_push_d = 1'b0;
    stack_pop_d  = 1'b0;
    push_data_d  = next_instr_addr(pc_i);
    pc_load_d    = 1'b0;
    pc_data_d    = return_stack_top_i;
    flush_d      = 1'b0;
    busy_d       = 1'b0;
    case (state_q)
      esx_pkg::ESX_EXEC: begin
        // Disabled extension: opcodes fall through untouched
        if (instr_valid_i && ext_sync_q) begin
          if (dec_add_ptr) begin
            // Add family: pointer write, plus a return when the select is 3
            ptr_we_d = 1'b1;
            if (dec_add_ret) begin
              stack_pop_d = 1'b1;
              pc_load_d   = 1'b1;
              flush_d     = 1'b1;
              busy_d      = 1'b1;
              state_d     = esx_pkg::ESX_IDLE;
            end
          end else if (dec_call) begin
            // Computed call: push the next address, jump via the latches and W
            stack_push_d = 1'b1;
            pc_load_d    = 1'b1;
            // Only PC and the return stack are written; W, status and bank select have no port here
            pc_data_d    = call_target(program_counter_upper_latch_i, program_counter_high_latch_i,
                                       working_reg_i);
            flush_d      = 1'b1;
            busy_d       = 1'b1;
            state_d      = esx_pkg::ESX_IDLE;
          end
        end
      end
      esx_pkg::ESX_IDLE: begin
        // Second cycle is a no-op while the new target is fetched
        state_d = esx_pkg::ESX_EXEC;
      end
      default: state_d = esx_pkg::ESX_EXEC;
    endcase
  end

  // ****************************************
  // State and output registers
  // ****************************************
  // Every output is registered so downstream sees clean strobes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q           <= esx_pkg::ESX_EXEC;
      ptr_we_o          <= 1'b0;
      ptr_sel_o         <= 2'h0;
      ptr_wdata_o       <= '0;
      stack_push_o      <= 1'b0;
      stack_pop_o       <= 1'b0;
      stack_push_data_o <= '0;
      pc_load_o         <= 1'b0;
      pc_load_data_o    <= '0;
      flush_o           <= 1'b0;
      busy_o            <= 1'b0;
    end else begin
      state_q           <= state_d;
      ptr_we_o          <= ptr_we_d;
      ptr_sel_o         <= ptr_sel_d;
      ptr_wdata_o       <= ptr_wdata_d;
      stack_push_o      <= stack_push_d;
      stack_pop_o       <= stack_pop_d;
      stack_push_data_o <= push_data_d;
      pc_load_o         <= pc_load_d;
      pc_load_data_o    <= pc_data_d;
      flush_o           <= flush_d;
      busy_o            <= busy_d;
    end
  end

endmodule : esx_exec

`default_nettype wire

// File: src/esx_pkg.sv
// Constants for the extended stack-op execute block.
// Assumes a 16-bit instruction word and a 21-bit program counter.
// Summary of operation
// - Add-literal-to-pointer (upper byte 1110 1000) adds the 6-bit literal to pointer 0..2, flags untouched.
// - Select field 11 adds the literal to the software stack pointer and returns from the return stack top.
// - The computed call 0000 0000 0001 0100 first pushes the next address, program counter plus 2.
// - The computed call then replaces the program counter low byte with the working register.
// - The high and upper program counter bytes are then loaded from their latches.
// - The computed call takes two cycles, the second an idle one while the target is fetched.
// - The computed call leaves the working register, status flags and bank select register alone.
// - These opcodes execute only while the extension enable bit is set, which is off by default.
package esx_pkg;

  // ****************************************
  // Opcode fields
  // ****************************************
  localparam logic [7:0]  ADD_PTR_HI   = 8'he8;
  localparam logic [15:0] CALL_WREG_OP = 16'h0014;
  localparam logic [1:0]  SEL_STACK    = 2'h3;
  localparam int          SEL_MSB      = 7;
  localparam int          SEL_LSB      = 6;
  localparam int          LIT_MSB      = 5;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int          PC_W       = 21;
  localparam int          PTR_W      = 12;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic        EXT_RESET  = 1'b0;

  typedef enum logic [0:0] {ESX_EXEC, ESX_IDLE} esx_state_e;

endpackage : esx_pkg

// File: testbench/esx_exec_chk.sv
// Port checker for the extended stack-op execute block.
// Assumes it is bound to every esx_exec instance.
`timescale 1ns/100ps
`default_nettype none
module esx_exec_chk (
  input wire logic clk_i, resetn_i, instr_valid_i, ptr_we_o, stack_push_o, stack_pop_o, pc_load_o, flush_o, busy_o,
  input wire logic extended_set_enable_bit_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0] working_reg_i, program_counter_high_latch_i, program_counter_upper_latch_i,
  input wire logic [esx_pkg::PC_W-1:0] pc_i, return_stack_top_i, stack_push_data_o, pc_load_data_o,
  input wire logic [esx_pkg::PTR_W-1:0] indirect_pointer0_i, ptr_wdata_o,
  input wire logic [1:0] ptr_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Outputs are tied to the instruction taken one edge earlier
  a_push_addr: assert property (stack_push_o |-> stack_push_data_o == $past(pc_i) + esx_pkg::PC_STEP)
    else $error("push address wrong");
  a_call_cause: assert property (stack_push_o |-> $past(instr_i) == esx_pkg::CALL_WREG_OP && busy_o)
    else $error("push without call");
  a_call_target: assert property (stack_push_o |-> pc_load_o && pc_load_data_o ==
    {$past(program_counter_upper_latch_i[4:0]), $past(program_counter_high_latch_i), $past(working_reg_i)})
    else $error("call target wrong");
  // Second cycle of a two-cycle op must be idle
  a_two_idle: assert property (stack_push_o || stack_pop_o |=> !(ptr_we_o || pc_load_o || busy_o))
    else $error("second cycle not idle");
  a_ret_load: assert property (stack_pop_o |-> pc_load_o && flush_o && ptr_we_o && ptr_sel_o == 2'h3
    && pc_load_data_o == $past(return_stack_top_i)) else $error("return wrong");
  a_ptr_sum: assert property (ptr_we_o && ptr_sel_o == 2'h0
    |-> ptr_wdata_o == $past(indirect_pointer0_i) + $past(instr_i[5:0])) else $error("pointer sum wrong");
  a_ptr_cause: assert property (ptr_we_o |-> $past(instr_valid_i) && $past(instr_i[15:8]) == esx_pkg::ADD_PTR_HI)
    else $error("pointer write without opcode");
  a_call_noptr: assert property (!(stack_push_o && ptr_we_o))
    else $error("call touched pointers");
  // Enable passes two flops, so it must have been high three edges back
  a_ext_gate: assert property (ptr_we_o || stack_push_o |-> $past(extended_set_enable_bit_i, 3))
    else $error("opcode ran with extension off");
endmodule : esx_exec_chk
bind esx_exec esx_exec_chk u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .extended_set_enable_bit_i(extended_set_enable_bit_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i), .working_reg_i(working_reg_i),
  .program_counter_high_latch_i(program_counter_high_latch_i),
  .program_counter_upper_latch_i(program_counter_upper_latch_i),
  .return_stack_top_i(return_stack_top_i), .indirect_pointer0_i(indirect_pointer0_i),
  .ptr_we_o(ptr_we_o), .ptr_sel_o(ptr_sel_o), .ptr_wdata_o(ptr_wdata_o),
  .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o), .stack_push_data_o(stack_push_data_o),
  .pc_load_o(pc_load_o), .pc_load_data_o(pc_load_data_o), .flush_o(flush_o), .busy_o(busy_o)
);
`default_nettype wire

// File: testbench/test_extended_stack_op_exec.sv
// Random bench for esx_exec, checked against expected values.
// Assumes esx_pkg and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_extended_stack_op_exec;
  logic clk_i = 0, resetn_i = 0, extended_set_enable_bit_i = 1, instr_valid_i = 0;
  logic [15:0] instr_i = 0;
  logic [7:0] working_reg_i = 0, program_counter_high_latch_i = 0, program_counter_upper_latch_i = 0;
  logic [esx_pkg::PC_W-1:0] pc_i = 0, return_stack_top_i = 0, stack_push_data_o, pc_load_data_o;
  logic [esx_pkg::PTR_W-1:0] indirect_pointer0_i = 0, indirect_pointer1_i = 0, software_stack_pointer_i = 0, ptr_wdata_o;
  logic ptr_we_o, stack_push_o, stack_pop_o, pc_load_o, flush_o, busy_o;
  logic [1:0] ptr_sel_o;
  int bad_count = 0, num_checks = 0;
  esx_exec dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .extended_set_enable_bit_i(extended_set_enable_bit_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i), .working_reg_i(working_reg_i),
    .program_counter_high_latch_i(program_counter_high_latch_i),
    .program_counter_upper_latch_i(program_counter_upper_latch_i), .return_stack_top_i(return_stack_top_i),
    .indirect_pointer0_i(indirect_pointer0_i), .indirect_pointer1_i(indirect_pointer1_i),
    .software_stack_pointer_i(software_stack_pointer_i), .ptr_we_o(ptr_we_o), .ptr_sel_o(ptr_sel_o),
    .ptr_wdata_o(ptr_wdata_o), .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
    .stack_push_data_o(stack_push_data_o), .pc_load_o(pc_load_o), .pc_load_data_o(pc_load_data_o),
    .flush_o(flush_o), .busy_o(busy_o)
  );
  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;
  task chk(input string n, input logic [20:0] e, input logic [20:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // One instruction at a falling edge, checked one cycle later
  // Expected pointer sum: select 2 and 3 both name the stack pointer
  function automatic logic [11:0] exp_sum(input logic [15:0] i, input logic [11:0] a, b, s);
    return (i[7:6] == 2'h0 ? a : i[7:6] == 2'h1 ? b : s) + 12'(i[5:0]);
  endfunction : exp_sum
  task automatic op(input logic [15:0] i, input bit on, input bit v = 1'b1);
    logic p, c, r;
    logic [11:0] e;
    logic [20:0] t;
    pc_i = 21'($urandom);
    return_stack_top_i = 21'($urandom);
    working_reg_i = 8'($urandom);
    program_counter_high_latch_i = 8'($urandom);
    program_counter_upper_latch_i = 8'($urandom);
    indirect_pointer0_i = 12'($urandom);
    indirect_pointer1_i = 12'($urandom);
    software_stack_pointer_i = 12'($urandom);
    instr_i = i;
    instr_valid_i = v;
    p = on && v && i[15:8] == esx_pkg::ADD_PTR_HI;
    c = on && v && i == esx_pkg::CALL_WREG_OP;
    r = p && i[7:6] == 2'h3;
    e = exp_sum(i, indirect_pointer0_i, indirect_pointer1_i, software_stack_pointer_i);
    t = {program_counter_upper_latch_i[4:0], program_counter_high_latch_i, working_reg_i};
    @(negedge clk_i);
    chk("ptr_we", p, ptr_we_o);
    chk("push", c, stack_push_o);
    chk("pop", r, stack_pop_o);
    chk("busy", c | r, busy_o);
    chk("pc_load", c | r, pc_load_o);
    chk("flush", c | r, flush_o);
    if (p) chk("ptr_data", e, ptr_wdata_o);
    if (p) chk("ptr_sel", i[7:6], ptr_sel_o);
    if (c) chk("push_data", pc_i + esx_pkg::PC_STEP, stack_push_data_o);
    if (c) chk("target", t, pc_load_data_o);
    if (r) chk("target", return_stack_top_i, pc_load_data_o);
    if (c | r) begin
      // An add sent into the idle cycle must be ignored
      instr_i = {esx_pkg::ADD_PTR_HI, 8'($urandom)};
      @(negedge clk_i);
      chk("idle_we", 0, ptr_we_o);
      chk("idle_load", 0, pc_load_o);
    end
  endtask : op
  initial begin
    void'($urandom(32'ha337edb7));
    repeat (12) @(negedge clk_i);
    resetn_i = 1;
    repeat (3) @(negedge clk_i);
    op(esx_pkg::CALL_WREG_OP, 1);
    op(esx_pkg::CALL_WREG_OP, 1);
    op({esx_pkg::ADD_PTR_HI, 8'hff}, 1);
    op({esx_pkg::ADD_PTR_HI, 8'h3f}, 1);
    op(esx_pkg::CALL_WREG_OP, 1, 1'b0);
    for (int n = 0; n < 400; n++) begin
      if (n == 300) begin
        // Extension off: nothing may execute
        instr_valid_i = 0;
        extended_set_enable_bit_i = 0;
        repeat (3) @(negedge clk_i);
      end
      case ($urandom % 4)
        0: op(esx_pkg::CALL_WREG_OP, n < 300, ($urandom % 8) != 0);
        1: op(16'($urandom), n < 300, ($urandom % 8) != 0);
        default: op({esx_pkg::ADD_PTR_HI, 8'($urandom)}, n < 300, ($urandom % 8) != 0);
      endcase
    end
    close_out;
  end
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule : test_extended_stack_op_exec
`default_nettype wire
